// ==== rtl/gcsl_top.sv ====
`timescale 1ns/1ps
// Purpose: Capacity-state logic of a single-cell battery gauge
// Assumes: Measurements and model values come from outside blocks
// Notes: Status register at 01h on a simple byte register port
module gcsl_top
	import gcsl_pkg::*;
#(
	parameter int COUNT_W = 16
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Measurements
	input wire logic meas_valid,
	input wire logic [15:0] voltage,
	input wire logic signed [15:0] current,
	input wire logic signed [15:0] averaged_current,
	input wire logic undervoltage,
	input wire logic [7:0] remaining_active_percent,
	input wire logic [7:0] remaining_standby_percent,
	input wire logic sleep_entry,
	// Stored parameters
	input wire logic [7:0] charge_voltage_threshold,
	input wire logic [7:0] termination_current_threshold,
	input wire logic [7:0] active_empty_voltage,
	input wire logic [7:0] active_empty_current,
	input wire logic [15:0] wear_reference_charge,
	input wire logic [7:0] derate_nv,
	// Host derate write and learned value
	input wire logic derate_wr,
	input wire logic [7:0] derate_wdata,
	input wire logic [7:0] learned_derate,
	// Model values at present temperature
	input wire logic [COUNT_W-1:0] full_model_scaled,
	input wire logic [COUNT_W-1:0] active_empty_model,
	// Coulomb count from accumulator
	input wire logic [COUNT_W-1:0] coulomb_count,
	input wire logic count_decrement,
	input wire logic count_host_load,
	// Results
	output logic [7:0] capacity_derate_factor,
	output logic count_load,
	output logic [COUNT_W-1:0] count_load_value,
	output logic [7:0] gauge_status
);
	typedef enum logic [1:0] {
		GCSL_IDLE = 2'b00,
		GCSL_DERATE = 2'b01,
		GCSL_LOAD = 2'b11
	} gcsl_full_e;

	gcsl_hist_if hist();
	gcsl_full_e full_state;
	logic charge_full_flag;
	logic active_low_flag;
	logic standby_low_flag;
	logic learn_flag;
	logic undervoltage_flag;
	logic power_on_flag;
	logic derate_loaded;
	logic [COUNT_W+GCSL_WEAR_MULT_LOG2-1:0] wear_count;
	logic [COUNT_W+GCSL_WEAR_MULT_LOG2-1:0] wear_limit;
	logic status_wr;
	logic learn_at_full;

	gcsl_detect u_detect (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.meas_valid(meas_valid),
		.voltage({8'h00, voltage[15:8]}),
		.current(current),
		.averaged_current(averaged_current),
		.charge_voltage_threshold({8'h00, charge_voltage_threshold}),
		.termination_current_threshold({8'h00,
			termination_current_threshold}),
		.active_empty_voltage({8'h00, active_empty_voltage}),
		.active_empty_current({8'h00, active_empty_current}),
		.hist(hist)
	);

	assign status_wr = reg_wr && (reg_addr == GCSL_STATUS_ADDR);
	assign wear_limit = (COUNT_W + GCSL_WEAR_MULT_LOG2)'({wear_reference_charge,
		GCSL_WEAR_MULT_LOG2'(0)});

	// Full sequence: derate update first, then count load
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			full_state <= GCSL_IDLE;
			learn_at_full <= 1'b0;
		end else begin
			case (full_state)
			GCSL_IDLE: begin
				if (hist.full_hit) begin
					learn_at_full <= learn_flag;
					full_state <= GCSL_DERATE;
				end
			end
			GCSL_DERATE: full_state <= GCSL_LOAD;
			GCSL_LOAD: full_state <= GCSL_IDLE;
			default: full_state <= GCSL_IDLE;
			endcase
		end
	end

	// Derate factor: recall, aging, learn, host write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			capacity_derate_factor <= GCSL_DERATE_UNAGED;
			derate_loaded <= 1'b0;
			wear_count <= '0;
		end else if (!derate_loaded) begin
			capacity_derate_factor <= derate_nv;
			derate_loaded <= 1'b1;
		end else if (full_state == GCSL_DERATE && learn_at_full) begin
			capacity_derate_factor <= (learned_derate < GCSL_DERATE_FLOOR) ?
				GCSL_DERATE_FLOOR : learned_derate;
		end else if (derate_wr) begin
			capacity_derate_factor <= derate_wdata;
		end else if (count_decrement) begin
			if (wear_count + 1'b1 >= wear_limit) begin
				wear_count <= '0;
				if (capacity_derate_factor > GCSL_DERATE_FLOOR)
					capacity_derate_factor <=
						capacity_derate_factor - 8'h01;
			end else begin
				wear_count <= wear_count + 1'b1;
			end
		end
	end

	// Coulomb count corrections
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_load <= 1'b0;
			count_load_value <= '0;
		end else begin
			count_load <= 1'b0;
			if (full_state == GCSL_LOAD) begin
				count_load <= 1'b1;
				count_load_value <= full_model_scaled;
			end else if (hist.empty_hit) begin
				// A real empty point reloads the empty model; learn is set with it
				count_load <= 1'b1;
				count_load_value <= active_empty_model;
			end else if (meas_valid && active_low_flag && !learn_flag &&
				coulomb_count > active_empty_model) begin
				count_load <= 1'b1;
				count_load_value <= active_empty_model;
			end
		end
	end

	// Charge-full flag
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			charge_full_flag <= 1'b0;
		else if (hist.full_hit)
			charge_full_flag <= 1'b1;
		else if (remaining_active_percent < GCSL_FULL_CLR_PCT)
			charge_full_flag <= 1'b0;
	end

	// Active-low flag, set wins
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			active_low_flag <= 1'b0;
		else if (meas_valid && voltage[15:8] < active_empty_voltage)
			active_low_flag <= 1'b1;
		else if (remaining_active_percent > GCSL_ALOW_CLR_PCT)
			active_low_flag <= 1'b0;
	end

	// Standby-low flag with hysteresis
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			standby_low_flag <= 1'b0;
		else if (remaining_standby_percent < GCSL_SLOW_SET_PCT)
			standby_low_flag <= 1'b1;
		else if (remaining_standby_percent > GCSL_SLOW_CLR_PCT)
			standby_low_flag <= 1'b0;
	end

	// Learn flag; a new empty point outranks the clear causes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			learn_flag <= 1'b0;
		else if (hist.empty_hit)
			learn_flag <= 1'b1;
		else if (hist.full_hit || (meas_valid && current < 16'sd0) ||
			coulomb_count == '0 || count_host_load || sleep_entry)
			learn_flag <= 1'b0;
	end

	// Host clearable flags; internal set wins over write of zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			undervoltage_flag <= 1'b1;
			power_on_flag <= 1'b1;
		end else begin
			if (undervoltage)
				undervoltage_flag <= 1'b1;
			else if (status_wr && !reg_wdata[GCSL_BIT_UV])
				undervoltage_flag <= 1'b0;
			if (status_wr && !reg_wdata[GCSL_BIT_POR])
				power_on_flag <= 1'b0;
		end
	end

	// Registered status image and read data
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			gauge_status <= 8'h00;
			reg_rdata <= 8'h00;
		end else begin
			gauge_status <= '0;
			gauge_status[GCSL_BIT_FULL] <= charge_full_flag;
			gauge_status[GCSL_BIT_ALOW] <= active_low_flag;
			gauge_status[GCSL_BIT_SLOW] <= standby_low_flag;
			gauge_status[GCSL_BIT_LEARN] <= learn_flag;
			gauge_status[GCSL_BIT_UV] <= undervoltage_flag;
			gauge_status[GCSL_BIT_POR] <= power_on_flag;
			reg_rdata <= (reg_addr == GCSL_STATUS_ADDR) ?
				gauge_status : 8'hFF;
		end
	end
endmodule

// ==== rtl/gcsl_pkg.sv ====
// Purpose: Shared constants for the gauge capacity-state logic
// Assumes: One clock domain, byte-wide register port
// Notes: Percent thresholds are whole percent units
package gcsl_pkg;
	localparam logic [7:0] GCSL_STATUS_ADDR = 8'h01;
	localparam int GCSL_BIT_FULL = 7;
	localparam int GCSL_BIT_ALOW = 6;
	localparam int GCSL_BIT_SLOW = 5;
	localparam int GCSL_BIT_LEARN = 4;
	localparam int GCSL_BIT_UV = 2;
	localparam int GCSL_BIT_POR = 1;
	localparam logic [7:0] GCSL_DERATE_UNAGED = 8'h80;
	localparam logic [7:0] GCSL_DERATE_FLOOR = 8'h40;
	localparam int GCSL_WEAR_MULT_LOG2 = 5;
	localparam logic [15:0] GCSL_AVERAGED_CURRENT_MIN = 16'h0010;
	localparam logic [7:0] GCSL_ALOW_CLR_PCT = 8'h05;
	localparam logic [7:0] GCSL_FULL_CLR_PCT = 8'h5A;
	localparam logic [7:0] GCSL_SLOW_SET_PCT = 8'h0A;
	localparam logic [7:0] GCSL_SLOW_CLR_PCT = 8'h0F;
endpackage

// ==== rtl/gcsl_hist_if.sv ====
`timescale 1ns/1ps
// Purpose: Carries current history between the top and the detector
// Assumes: Signed 16-bit current readings
// Notes: Driven by the detector, read by the top
interface gcsl_hist_if;
	logic full_hit;
	logic empty_hit;
	logic two_discharge;
	modport det (output full_hit, output empty_hit, output two_discharge);
	modport top (input full_hit, input empty_hit, input two_discharge);
endinterface

// ==== rtl/gcsl_detect.sv ====
`timescale 1ns/1ps
// Purpose: Full and active-empty point detection per measurement update
// Assumes: meas_valid pulses once per new reading
// Notes: Hit outputs are one-cycle pulses aligned after the update
module gcsl_detect
	import gcsl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Measurements
	input wire logic meas_valid,
	input wire logic [15:0] voltage,
	input wire logic signed [15:0] current,
	input wire logic signed [15:0] averaged_current,
	// Thresholds, voltage and current scaled to reading units
	input wire logic [15:0] charge_voltage_threshold,
	input wire logic [15:0] termination_current_threshold,
	input wire logic [15:0] active_empty_voltage,
	input wire logic [15:0] active_empty_current,
	// Results
	gcsl_hist_if.det hist
);
	logic [1:0] cur_dis;
	logic [1:0] averaged_current_ok;
	logic [1:0] v_hi;
	logic averaged_current_q;
	logic cur_q;
	logic v_q;

	// Readings that qualify, judged on the new sample
	always_comb begin
		averaged_current_q = (averaged_current > $signed(GCSL_AVERAGED_CURRENT_MIN)) &&
			($unsigned(averaged_current) <
			termination_current_threshold);
		cur_q = (current < 16'sd0) &&
			($unsigned(-current) > active_empty_current);
		v_q = voltage > charge_voltage_threshold;
	end

	// History of the two previous readings
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_dis <= 2'b00;
			averaged_current_ok <= 2'b00;
			v_hi <= 2'b00;
		end else if (meas_valid) begin
			cur_dis <= {cur_dis[0], cur_q};
			averaged_current_ok <= {averaged_current_ok[0], averaged_current_q};
			v_hi <= {v_hi[0], v_q};
		end
	end

	// Empty check uses history before this sample joins it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hist.full_hit <= 1'b0;
			hist.empty_hit <= 1'b0;
		end else begin
			hist.full_hit <= meas_valid && averaged_current_q && v_q &&
				averaged_current_ok[0] && v_hi[0];
			hist.empty_hit <= meas_valid && hist.two_discharge &&
				(voltage < active_empty_voltage);
		end
	end

	assign hist.two_discharge = &cur_dis;
endmodule

// ==== sim/gcsl_top_asserts.sv ====
// Purpose: Port-level checks of the capacity-state logic
// Assumes: One clock domain, bench holds model values steady
// Notes: Attached to every top instance by bind
`timescale 1ns/1ps
module gcsl_top_asserts
	import gcsl_pkg::*;
#(
	parameter int COUNT_W = 16
)
(
	// Clock, reset and register port
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Measurements and parameters
	input wire logic meas_valid,
	input wire logic [15:0] voltage,
	input wire logic undervoltage,
	input wire logic [7:0] remaining_standby_percent,
	input wire logic [7:0] active_empty_voltage,
	input wire logic derate_wr,
	input wire logic [COUNT_W-1:0] full_model_scaled,
	input wire logic [COUNT_W-1:0] active_empty_model,
	// Results
	input wire logic [7:0] capacity_derate_factor,
	input wire logic count_load,
	input wire logic [COUNT_W-1:0] count_load_value,
	input wire logic [7:0] gauge_status
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire clr_w = reg_wr && reg_addr == GCSL_STATUS_ADDR;
	wire por_w = clr_w && !reg_wdata[GCSL_BIT_POR];
	// Undervoltage clear counts only once the input has recovered
	wire uv_w = clr_w && !reg_wdata[GCSL_BIT_UV] && !undervoltage;
	property p_rdata_ff;
		rst_b && reg_addr != GCSL_STATUS_ADDR |=> reg_rdata == 8'hFF;
	endproperty
	a_rdata_ff: assert property (p_rdata_ff)
		else $error("unmapped read not FFh");
	property p_rsvd;
		!gauge_status[3] && !gauge_status[0];
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved status bit set");
	property p_floor;
		capacity_derate_factor == GCSL_DERATE_FLOOR && !derate_wr
			|=> capacity_derate_factor >= GCSL_DERATE_FLOOR;
	endproperty
	a_floor: assert property (p_floor)
		else $error("derate fell below floor");
	property p_full_load;
		count_load && count_load_value == full_model_scaled
			|-> ##[0:2] gauge_status[GCSL_BIT_FULL];
	endproperty
	a_full_load: assert property (p_full_load)
		else $error("full load without full flag");
	property p_load_val;
		count_load |-> count_load_value == full_model_scaled
			|| count_load_value == active_empty_model;
	endproperty
	a_load_val: assert property (p_load_val)
		else $error("count load value not a model value");
	property p_por_fall;
		$fell(gauge_status[GCSL_BIT_POR]) |-> $past(por_w) || $past(por_w, 2);
	endproperty
	a_por_fall: assert property (p_por_fall)
		else $error("power-on flag cleared without write");
	property p_uv_fall;
		$fell(gauge_status[GCSL_BIT_UV]) |-> $past(uv_w) || $past(uv_w, 2);
	endproperty
	a_uv_fall: assert property (p_uv_fall)
		else $error("undervoltage flag cleared wrongly");
	property p_slow_fall;
		$fell(gauge_status[GCSL_BIT_SLOW]) |->
			$past(remaining_standby_percent) > GCSL_SLOW_CLR_PCT ||
			$past(remaining_standby_percent, 2) > GCSL_SLOW_CLR_PCT;
	endproperty
	a_slow_fall: assert property (p_slow_fall)
		else $error("standby-low cleared inside hysteresis");
	property p_alow_set;
		meas_valid && voltage[15:8] < active_empty_voltage
			|-> ##[1:3] gauge_status[GCSL_BIT_ALOW];
	endproperty
	a_alow_set: assert property (p_alow_set)
		else $error("active-low not set on low voltage");
endmodule
bind gcsl_top gcsl_top_asserts #(.COUNT_W(COUNT_W)) u_chk (.*);

// ==== sim/gcsl_top_bench.sv ====
// Purpose: Self-checking bench for the capacity-state logic
// Assumes: Default count width, model values distinct
// Notes: Random standby percentages exercise the hysteresis
`timescale 1ns/1ps
module gcsl_top_bench;
	import gcsl_pkg::*;
	logic ref_clk = 0, rst_b = 0, reg_wr = 0, meas_valid = 0;
	logic undervoltage = 1, sleep_entry = 0, derate_wr = 0;
	logic count_decrement = 0, count_host_load = 0, count_load, slow_e = 0;
	logic [7:0] reg_addr = 8'h01, reg_wdata = 8'h00, derate_wdata = 8'h00;
	logic [7:0] remaining_active_percent = 8'h5F, p;
	logic [7:0] remaining_standby_percent = 8'h32;
	logic [7:0] charge_voltage_threshold = 8'hD0;
	logic [7:0] termination_current_threshold = 8'hFF;
	logic [7:0] active_empty_voltage = 8'h9A, active_empty_current = 8'h01;
	logic [7:0] derate_nv = 8'h79, learned_derate = 8'h7C;
	logic [7:0] reg_rdata, capacity_derate_factor, gauge_status;
	logic [15:0] voltage = 16'hC000, wear_reference_charge = 16'h0002;
	logic signed [15:0] current = 16'h0000, averaged_current = 16'h0000;
	logic [15:0] full_model_scaled = 16'h3000, active_empty_model = 16'h0800;
	logic [15:0] coulomb_count = 16'h1000, count_load_value, last_load = 0;
	logic [7:0] corner [4] = '{8'h09, 8'h0A, 8'h0F, 8'h10};
	int err_total = 0, compares = 0, cycles = 0, seed = 322, i, k, n;
	int loads = 0;
	gcsl_top uut (.*);
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (count_load === 1'b1) begin
			last_load <= count_load_value;
			loads <= loads + 1;
		end
		if (cycles == 20000) begin
			err_total = err_total + 1;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr_status(input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= GCSL_STATUS_ADDR;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge ref_clk);
		reg_addr <= a;
		tick(2);
		chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic meas(input logic [15:0] v, c);
		@(posedge ref_clk);
		meas_valid <= 1'b1;
		voltage <= v;
		current <= c;
		averaged_current <= c;
		@(posedge ref_clk);
		meas_valid <= 1'b0;
	endtask
	task automatic decs(input int c);
		repeat (c) begin
			@(posedge ref_clk);
			count_decrement <= 1'b1;
			@(posedge ref_clk);
			count_decrement <= 1'b0;
		end
		tick(2);
	endtask
	// Two strong discharge samples, then the voltage drops
	task automatic empty_point();
		meas(16'hC000, 16'hF830);
		meas(16'hC000, 16'hF830);
		meas(16'h9000, 16'hF830);
		tick(3);
	endtask
	function automatic logic slow_next(input logic cur, input logic [7:0] v);
		if (v < GCSL_SLOW_SET_PCT)
			return 1'b1;
		if (v > GCSL_SLOW_CLR_PCT)
			return 1'b0;
		return cur;
	endfunction
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		tick(3);
		chk("status", 8'h06, gauge_status);
		chk("derate", derate_nv, capacity_derate_factor);
		rd(8'h20, 8'hFF);
		wr_status(8'hFF);
		rd(GCSL_STATUS_ADDR, 8'h06);
		wr_status(8'h00);
		rd(GCSL_STATUS_ADDR, 8'h04);
		@(posedge ref_clk);
		undervoltage <= 1'b0;
		wr_status(8'h00);
		rd(GCSL_STATUS_ADDR, 8'h00);
		@(posedge ref_clk);
		undervoltage <= 1'b1;
		@(posedge ref_clk);
		undervoltage <= 1'b0;
		rd(GCSL_STATUS_ADDR, 8'h04);
		for (k = 0; k < 2; k++) begin
			decs(63);
			chk("derate", 16'(8'h79 - k), capacity_derate_factor);
			decs(1);
			chk("derate", 16'(8'h78 - k), capacity_derate_factor);
		end
		@(posedge ref_clk);
		derate_wr <= 1'b1;
		derate_wdata <= 8'h41;
		@(posedge ref_clk);
		derate_wr <= 1'b0;
		decs(128);
		chk("derate", GCSL_DERATE_FLOOR, capacity_derate_factor);
		for (i = 0; i < 24; i++) begin
			p = (i < 4) ? corner[i] : 8'($unsigned($random(seed)) % 21);
			@(posedge ref_clk);
			remaining_standby_percent <= p;
			tick(3);
			slow_e = slow_next(slow_e, p);
			chk("slow", slow_e, gauge_status[GCSL_BIT_SLOW]);
		end
		empty_point();
		chk("learn", 1'b1, gauge_status[GCSL_BIT_LEARN]);
		chk("load", active_empty_model, last_load);
		meas(16'hD800, 16'h0014);
		meas(16'hD800, 16'h0014);
		tick(4);
		chk("full", 1'b1, gauge_status[GCSL_BIT_FULL]);
		chk("learn", 1'b0, gauge_status[GCSL_BIT_LEARN]);
		chk("derate", learned_derate, capacity_derate_factor);
		chk("load", full_model_scaled, last_load);
		for (k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			remaining_active_percent <= 8'h5A - k;
			tick(3);
			chk("full", 16'(k == 0), gauge_status[GCSL_BIT_FULL]);
		end
		for (k = 0; k < 3; k++) begin
			empty_point();
			@(posedge ref_clk);
			count_host_load <= (k == 0);
			sleep_entry <= (k == 1);
			@(posedge ref_clk);
			count_host_load <= 1'b0;
			sleep_entry <= 1'b0;
			if (k == 2)
				meas(16'hC000, 16'hFFF0);
			tick(3);
			chk("learn", 1'b0, gauge_status[GCSL_BIT_LEARN]);
		end
		// Keep active-low set and flush the discharge history first
		@(posedge ref_clk);
		remaining_active_percent <= 8'h03;
		meas(16'hC000, 16'h0014);
		meas(16'hC000, 16'h0014);
		n = loads;
		meas(16'h9000, 16'h0014);
		meas(16'h9000, 16'h0014);
		tick(3);
		chk("loads", 16'(n + 1), 16'(loads));
		chk("load", active_empty_model, last_load);
		n = loads;
		@(posedge ref_clk);
		coulomb_count <= 16'h0400;
		meas(16'h9000, 16'h0014);
		tick(3);
		chk("loads", 16'(n), 16'(loads));
		complete_run();
	end
endmodule
